// *** src/fbmec_pkg.sv ***
// Constants, field layouts and types of the fieldbus master mode and exchange controller.
// Assumes a 32-bit Avalon-MM register bus with byte addresses, one register per word.
package fbmec_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_MODE_REQ = 12'h8CF;
  localparam logic [IDX_W-1:0] IDX_MODE_RES = 12'h8D0;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'h900;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'h901;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h902;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 12'h903;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 12'h904;
  localparam logic [IDX_W-1:0] IDX_SLV_CNT = 12'h905;
  localparam logic [IDX_W-1:0] IDX_LEN_BASE = 12'h940;
  localparam logic [IDX_W-1:0] IDX_OFF_BASE = 12'h980;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MCR_BIT = 0;
  localparam int CTRL_XSR_BIT = 1;
  localparam int CTRL_STOPSW_LSB = 16;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_XACT_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_MODE_LSB = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_XSTOP_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int OFF_OUT_LSB = 16;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [15:0] MODE_NORMAL = 16'h0000;
  localparam logic [15:0] MODE_PARAM = 16'h0001;
  localparam logic [15:0] MODE_DIAG = 16'h0002;
  localparam logic [15:0] MODE_EXT = 16'h000E;
  localparam logic [15:0] MODE_FLASH_INIT = 16'h000F;
  localparam logic [15:0] RESULT_OK = 16'h0000;
  localparam logic [15:0] RESULT_FAIL = 16'h0001;
  localparam logic [15:0] STOPSW_HALT = 16'h0001;
  localparam logic [15:0] MODE_RESET = MODE_PARAM;
  localparam logic [15:0] RESULT_RESET = RESULT_OK;
  localparam logic [15:0] MODE_REQ_RESET = MODE_NORMAL;

  // ****************************************
  // Slave area limits
  // ****************************************
  localparam int MAX_SLAVES = 60;
  localparam int SLV_IDX_W = 6;
  localparam int OFF_W = 11;
  localparam int SUM_W = 14;
  localparam int FIXED_SLOT_BYTES = 32;
  localparam int FIXED_SLOT_WORDS = 16;
  localparam int MAX_SLAVE_BYTES = 244;
  localparam int MAX_TOTAL_BYTES = 1920;

  typedef enum logic [2:0] {S_IDLE, S_HALT, S_SWITCH, S_CALC, S_DONE} fbmec_state_type;

endpackage

// *** src/fbmec_layout_if.sv ***
// Carrier between the controller and the slave area layout engine.
// Assumes one clock; all members are sampled on the controller clock.
`timescale 1ns/10ps
interface fbmec_layout_if;
  import fbmec_pkg::*;
  logic start;
  logic ext_mode;
  logic [SLV_IDX_W-1:0] slave_cnt;
  logic [SLV_IDX_W-1:0] rd_idx;
  logic [15:0] rd_len;
  logic busy;
  logic done;
  logic ok;
  logic [SLV_IDX_W-1:0] off_idx;
  logic [2*OFF_W-1:0] off_data;
  modport ctrl (output start, ext_mode, slave_cnt, rd_len, off_idx,
    input rd_idx, busy, done, ok, off_data);
  modport calc (input start, ext_mode, slave_cnt, rd_len, off_idx,
    output rd_idx, busy, done, ok, off_data);
endinterface

// *** src/fbmec_layout.sv ***
// Slave area layout engine: walks the per-slave length table, checks limits and
// records each slave's input and output offsets. Assumes the length table is read
// combinationally through the carrier and holds still during a walk.
`timescale 1ns/10ps
module fbmec_layout (
  input wire logic clk,
  input wire logic rst_n,
  fbmec_layout_if.calc lay
);
  import fbmec_pkg::*;

  logic [2*OFF_W-1:0] off_mem [MAX_SLAVES];
  logic [SLV_IDX_W-1:0] idx_r;
  logic [SLV_IDX_W-1:0] last_idx;
  logic busy_r, ok_r, done_r, cnt_bad, len_bad;
  logic [SUM_W-1:0] in_sum_r, out_sum_r, in_next, out_next;
  logic [7:0] in_len, out_len;

  // Fixed slots ignore the table entirely
  assign in_len = lay.ext_mode ? lay.rd_len[7:0] : 8'(FIXED_SLOT_BYTES); // [R7]
  assign out_len = lay.ext_mode ? lay.rd_len[15:8] : 8'(FIXED_SLOT_BYTES); // [R7]
  assign in_next = in_sum_r + SUM_W'(in_len);
  assign out_next = out_sum_r + SUM_W'(out_len);
  assign last_idx = lay.ext_mode ? lay.slave_cnt - 6'h01 : SLV_IDX_W'(MAX_SLAVES - 1); // [R8]
  assign cnt_bad = lay.ext_mode && (lay.slave_cnt == 6'h00 ||
    lay.slave_cnt > SLV_IDX_W'(MAX_SLAVES)); // [R10]
  assign len_bad = in_len > 8'(MAX_SLAVE_BYTES) || out_len > 8'(MAX_SLAVE_BYTES) ||
    in_next > SUM_W'(MAX_TOTAL_BYTES) || out_next > SUM_W'(MAX_TOTAL_BYTES); // [R11]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      idx_r <= '0;
      in_sum_r <= '0;
      out_sum_r <= '0;
    end else if (lay.start) begin
      busy_r <= !cnt_bad;
      done_r <= cnt_bad;
      ok_r <= !cnt_bad;
      idx_r <= '0;
      in_sum_r <= '0;
      out_sum_r <= '0;
    end else if (busy_r) begin
      // Running sums give back-to-back areas with no gaps
      in_sum_r <= in_next; // [R12]
      out_sum_r <= out_next; // [R12]
      if (len_bad) begin
        ok_r <= 1'b0; // [R11]
      end
      idx_r <= idx_r + 6'h01;
      if (idx_r == last_idx) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end else begin
      done_r <= 1'b0;
    end
  end

  // No reset: the table is only meaningful after a completed walk
  always_ff @(posedge clk) begin
    if (busy_r) begin
      off_mem[idx_r] <= {out_sum_r[OFF_W-1:0], in_sum_r[OFF_W-1:0]}; // [R12]
    end
  end

  assign lay.rd_idx = idx_r;
  assign lay.busy = busy_r;
  assign lay.done = done_r;
  assign lay.ok = ok_r;
  assign lay.off_data = off_mem[lay.off_idx];

  a_fixed_slot_size: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    busy_r && !lay.ext_mode |-> in_sum_r == SUM_W'(idx_r) * SUM_W'(FIXED_SLOT_WORDS * 2))
    else $error("fixed slot offset is not 32 bytes per slave");
  a_fixed_slave_count: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    done_r && !lay.ext_mode |-> ok_r && idx_r == SLV_IDX_W'(MAX_SLAVES))
    else $error("fixed layout did not cover sixty slaves");
  a_total_limit: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    done_r && ok_r |-> in_sum_r <= SUM_W'(MAX_TOTAL_BYTES) &&
      out_sum_r <= SUM_W'(MAX_TOTAL_BYTES))
    else $error("accepted layout exceeds the total byte limit");
  a_count_range: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    $rose(done_r) && ok_r && lay.ext_mode |-> lay.slave_cnt != 6'h00 &&
      lay.slave_cnt <= SLV_IDX_W'(MAX_SLAVES))
    else $error("variable layout accepted with an illegal slave count");
endmodule

// *** src/fbmec_irq.sv ***
// Sticky event flags with enable mask and one level interrupt.
// Assumes set pulses and clear strobes are synchronous to clk.
`timescale 1ns/10ps
module fbmec_irq #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic clr_we,
  input wire logic [W-1:0] clr,
  input wire logic en_we,
  input wire logic [W-1:0] en_d,
  output logic [W-1:0] stat,
  output logic [W-1:0] en,
  output logic irq
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      // Set wins over a clear in the same cycle so no event is lost
      stat <= (stat & ~(clr_we ? clr : '0)) | set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= '0;
      irq <= 1'b0;
    end else begin
      if (en_we) begin
        en <= en_d;
      end
      irq <= |(stat & en);
    end
  end
endmodule

// *** src/fbmec_top.sv ***
// Fieldbus master mode change handshake and cyclic exchange control, Avalon-MM slave.
// Assumes inputs synchronous to CLOCK and a master that holds each request until
// it samples WAITREQUEST low.
//
// Overview of operation
// R1: The host writes the wanted mode code into the request word before raising the request.
// R2: After switching, the device writes the outcome to the result word and raises completion.
// R3: The host checks the result reads zero for success and then drops the request.
// R4: When the host drops the request the device drops completion, ending the handshake.
// R5: A failed mode switch stores one, abnormal completion, in the result word.
// R6: A mode change during exchange first halts exchange and drops exchange-active, then switches.
// R7: Fixed-slot mode gives every slave a constant 32-byte, 16-word slot in the I/O area.
// R8: Fixed-slot mode supports exactly sixty slave stations.
// R9: Slave data moves only while exchange-active is high and stays untouched otherwise.
// R10: Variable-slot mode accepts one to sixty slaves, each with its own byte length.
// R11: Variable-slot mode limits each slave to 244 bytes and all slaves to 1920 bytes.
// R12: Variable-slot mode packs slave areas back to back with no gaps.
// R13: With the stop switch blank, a host stop error keeps exchange running on held outputs.
// R14: With the stop switch at one, a host stop error halts exchange and freezes inputs.
// R15: The host starts cyclic exchange by raising the exchange start request.
// R16: The result word keeps its value until the next mode change request is accepted.
`timescale 1ns/10ps
module fbmec_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [fbmec_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [fbmec_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [fbmec_pkg::DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  input wire logic CPU_STOP_ERROR,
  output logic EXCH_ACTIVE,
  output logic OUT_HOLD,
  output logic IRQ
);
  import fbmec_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r, rst_n;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ****************************************
  // Declarations
  // ****************************************
  fbmec_layout_if lay ();
  fbmec_state_type state_r;
  logic wait_r, wr_fire;
  logic [DATA_W-1:0] readdata_r, rd_data, wr_val;
  logic [IDX_W-1:0] idx;
  logic in_len_win, in_off_win;
  logic [SLV_IDX_W-1:0] len_slot;
  logic [15:0] len_mem [MAX_SLAVES];
  logic [15:0] mode_req_r, mode_r, result_r, code_r, stop_sw_r;
  logic mcr_r, xsr_r, done_r, exch_active_r, out_hold_r;
  logic [SLV_IDX_W-1:0] slave_cnt_r;
  logic svc_code, code_known, finish, finish_ok, stop_halt, exch_nxt;
  logic [IRQ_W-1:0] irq_set, irq_stat, irq_en;

  assign idx = ADDRESS[ADDR_W-1:2];
  assign in_len_win = idx >= IDX_LEN_BASE && idx < IDX_LEN_BASE + IDX_W'(MAX_SLAVES);
  assign in_off_win = idx >= IDX_OFF_BASE && idx < IDX_OFF_BASE + IDX_W'(MAX_SLAVES);
  assign len_slot = in_len_win ? SLV_IDX_W'(idx - IDX_LEN_BASE) : SLV_IDX_W'(idx - IDX_OFF_BASE);

  // ****************************************
  // Avalon-MM slave, one wait state per access
  // ****************************************
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      readdata_r <= '0;
    end else if ((READ || WRITE) && wait_r) begin
      wait_r <= 1'b0;
      readdata_r <= READ ? rd_data : '0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // A write lands at the edge where the master sees waitrequest low
  assign wr_fire = WRITE && !wait_r;

  always_comb begin
    rd_data = '0;
    if (in_len_win) begin
      rd_data = {16'h0000, len_mem[len_slot]};
    end else if (in_off_win) begin
      rd_data = {5'h00, lay.off_data[2*OFF_W-1:OFF_W], 5'h00, lay.off_data[OFF_W-1:0]};
    end else begin
      unique case (idx)
        IDX_MODE_REQ: rd_data = {16'h0000, mode_req_r};
        IDX_MODE_RES: rd_data = {16'h0000, result_r};
        IDX_CTRL: begin
          rd_data[CTRL_MCR_BIT] = mcr_r;
          rd_data[CTRL_XSR_BIT] = xsr_r;
          rd_data[CTRL_STOPSW_LSB+:16] = stop_sw_r;
        end
        IDX_STATUS: begin
          rd_data[STAT_DONE_BIT] = done_r;
          rd_data[STAT_XACT_BIT] = exch_active_r;
          rd_data[STAT_BUSY_BIT] = lay.busy;
          rd_data[STAT_MODE_LSB+:16] = mode_r;
        end
        IDX_IRQ_STAT: rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_stat};
        IDX_IRQ_EN: rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_en};
        IDX_SLV_CNT: rd_data = {{(DATA_W-SLV_IDX_W){1'b0}}, slave_cnt_r};
        default: rd_data = '0;
      endcase
    end
  end

  // Byte lanes merge into the addressed register's current contents, except at IDX_IRQ_EN and IDX_IRQ_CLR, which take WRITEDATA whole
  always_comb begin
    wr_val = rd_data;
    for (int b = 0; b < 4; b++) begin
      if (BYTEENABLE[b]) begin
        wr_val[8*b+:8] = WRITEDATA[8*b+:8];
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mode_req_r <= MODE_REQ_RESET;
      mcr_r <= 1'b0;
      xsr_r <= 1'b0;
      stop_sw_r <= '0;
      slave_cnt_r <= '0;
    end else if (wr_fire) begin
      if (idx == IDX_MODE_REQ) begin
        mode_req_r <= wr_val[15:0]; // [R1]
      end
      if (idx == IDX_CTRL) begin
        mcr_r <= wr_val[CTRL_MCR_BIT];
        xsr_r <= wr_val[CTRL_XSR_BIT]; // [R15]
        stop_sw_r <= wr_val[CTRL_STOPSW_LSB+:16];
      end
      if (idx == IDX_SLV_CNT) begin
        slave_cnt_r <= wr_val[SLV_IDX_W-1:0];
      end
    end
  end

  // Length table: in bytes [7:0], out bytes [15:8]; no reset, software fills it
  always_ff @(posedge CLOCK) begin
    if (wr_fire && in_len_win) begin
      len_mem[len_slot] <= wr_val[15:0]; // [R10]
    end
  end

  // ****************************************
  // Mode change handshake
  // ****************************************
  assign svc_code = code_r == MODE_NORMAL || code_r == MODE_EXT;
  assign code_known = svc_code || code_r == MODE_PARAM || code_r == MODE_DIAG ||
    code_r == MODE_FLASH_INIT;
  assign finish = (state_r == S_SWITCH && !svc_code) || (state_r == S_CALC && lay.done);
  assign finish_ok = state_r == S_SWITCH ? code_known : lay.ok;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      code_r <= MODE_REQ_RESET;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (mcr_r) begin
            // The code is taken as the request is seen
            code_r <= mode_req_r; // [R1]
            state_r <= exch_active_r ? S_HALT : S_SWITCH; // [R6]
          end
        end
        S_HALT: begin
          if (!exch_active_r) begin
            state_r <= S_SWITCH; // [R6]
          end
        end
        S_SWITCH: state_r <= svc_code ? S_CALC : S_DONE;
        S_CALC: begin
          if (lay.done) begin
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          if (!mcr_r) begin
            state_r <= S_IDLE; // [R4]
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      result_r <= RESULT_RESET;
      mode_r <= MODE_RESET;
    end else begin
      if (finish) begin
        done_r <= 1'b1; // [R2]
        result_r <= finish_ok ? RESULT_OK : RESULT_FAIL; // [R2] [R5] [R16]
        if (finish_ok) begin
          mode_r <= code_r;
        end
      end else if (state_r == S_DONE && !mcr_r) begin
        done_r <= 1'b0; // [R4]
      end
    end
  end

  // Walk starts from the switch state so the old mode's table stays readable until then
  assign lay.start = state_r == S_SWITCH && svc_code;
  assign lay.ext_mode = code_r == MODE_EXT; // [R10]
  assign lay.slave_cnt = slave_cnt_r;
  assign lay.rd_len = len_mem[lay.rd_idx];
  assign lay.off_idx = len_slot;

  fbmec_layout u_layout (
    .clk(CLOCK),
    .rst_n(rst_n),
    .lay(lay)
  );

  // ****************************************
  // Cyclic exchange control
  // ****************************************
  assign stop_halt = CPU_STOP_ERROR && stop_sw_r == STOPSW_HALT; // [R14]
  // Any pending or running mode change keeps exchange down
  assign exch_nxt = xsr_r && state_r == S_IDLE && !mcr_r && !stop_halt &&
    (mode_r == MODE_NORMAL || mode_r == MODE_EXT); // [R6] [R9] [R15]

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      exch_active_r <= 1'b0;
      out_hold_r <= 1'b0;
    end else begin
      exch_active_r <= exch_nxt; // [R9]
      // Outputs keep their pre-error values while inputs still refresh
      out_hold_r <= exch_nxt && CPU_STOP_ERROR; // [R13]
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_set[IRQ_DONE_BIT] = finish && finish_ok;
  assign irq_set[IRQ_FAIL_BIT] = finish && !finish_ok;
  assign irq_set[IRQ_XSTOP_BIT] = exch_active_r && !exch_nxt && stop_halt;

  fbmec_irq #(
    .W(IRQ_W)
  ) u_irq (
    .clk(CLOCK),
    .rst_n(rst_n),
    .set(irq_set),
    .clr_we(wr_fire && idx == IDX_IRQ_CLR),
    .clr(WRITEDATA[IRQ_W-1:0]),
    .en_we(wr_fire && idx == IDX_IRQ_EN),
    .en_d(WRITEDATA[IRQ_W-1:0]),
    .stat(irq_stat),
    .en(irq_en),
    .irq(IRQ)
  );

  assign READDATA = readdata_r;
  assign WAITREQUEST = wait_r;
  assign EXCH_ACTIVE = exch_active_r;
  assign OUT_HOLD = out_hold_r;

  // ****************************************
  // Checks
  // ****************************************
  a_compl_after_req: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R2]
    $rose(done_r) |-> mcr_r && $past(state_r) inside {S_SWITCH, S_CALC})
    else $error("completion rose without a pending request");
  a_compl_drops: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R4]
    done_r && !mcr_r |=> !done_r ##1 state_r == S_IDLE)
    else $error("completion did not drop after request fell");
  a_halt_first: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R6]
    state_r inside {S_SWITCH, S_CALC, S_DONE} |-> !exch_active_r)
    else $error("mode switched while exchange was active");
  a_fail_code_one: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R5]
    state_r == S_SWITCH && !code_known |=> done_r && result_r == 16'h0001)
    else $error("failed switch did not store the abnormal code");
  a_result_hold: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R16]
    !finish |=> $stable(result_r))
    else $error("result word changed outside a switch");
  a_stop_halts: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R14]
    CPU_STOP_ERROR && stop_sw_r == 16'h0001 |=> !exch_active_r && !out_hold_r)
    else $error("exchange kept running under halting stop error");
  a_stop_keeps: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R13]
    exch_active_r && CPU_STOP_ERROR && stop_sw_r == 16'h0000 && xsr_r && !mcr_r &&
      state_r == S_IDLE |=> exch_active_r && out_hold_r)
    else $error("exchange stopped under blank stop switch");
  a_xchg_svc_only: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R9]
    exch_active_r |-> $past(xsr_r) && (mode_r == MODE_NORMAL || mode_r == MODE_EXT))
    else $error("exchange active outside a service mode or without request");

  // ****************************************
  // Further checks
  // ****************************************
  a_code_taken: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R1]
    state_r == S_IDLE && mcr_r |=> code_r == $past(mode_req_r))
    else $error("code not taken");
  a_ok_sets_mode: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R2]
    finish && finish_ok |=> mode_r == $past(code_r))
    else $error("mode not switched");
  // A refused code leaves the old mode in force
  a_fail_keeps_mode: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R5]
    finish && !finish_ok |=> $stable(mode_r))
    else $error("mode changed on failure");

  a_start_needed: assert property (@(posedge CLOCK) disable iff (!rst_n) // [R15]
    !xsr_r |=> !exch_active_r)
    else $error("exchange without start");
  a_irq_quiet: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (irq_stat & irq_en) == '0 |=> !IRQ)
    else $error("interrupt not cleared");

  // One wait state, so no two low cycles
  a_wait_single: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !wait_r |=> wait_r)
    else $error("waitrequest low twice");
  a_irq_raise: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (irq_stat & irq_en) != '0 |=> IRQ)
    else $error("interrupt not raised");
endmodule

// *** tb/fbmec_host.sv ***
// Host CPU model: an Avalon-MM master that runs one register access at a time.
// Assumes the slave answers by dropping waitrequest for one cycle.
`timescale 1ns/10ps
module fbmec_host (
  input wire logic clk,
  output logic [fbmec_pkg::ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [fbmec_pkg::DATA_W-1:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [fbmec_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  import fbmec_pkg::*;
  initial begin
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'hF;
  end

  // ****************************************
  // One access, held until waitrequest is seen low at a rising edge
  // ****************************************
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show no stale value
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule

// *** tb/fieldbus_master_mode_exchange_ctrl_tb.sv ***
// Self-checking bench for the mode change handshake and exchange control.
// Assumes the host model drives the register bus and the bench drives stop error.
`timescale 1ns/10ps
module fieldbus_master_mode_exchange_ctrl_tb;
  import fbmec_pkg::*;
  logic clock, resetn, stop, rd_s, wr_s, waitreq, exch, hold, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] be;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  fbmec_top u_dut (.CLOCK(clock), .RESETN(resetn), .ADDRESS(addr), .READ(rd_s), .WRITE(wr_s),
    .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(waitreq),
    .CPU_STOP_ERROR(stop), .EXCH_ACTIVE(exch), .OUT_HOLD(hold), .IRQ(irq));
  fbmec_host u_host (.clk(clock), .address(addr), .read(rd_s), .write(wr_s),
    .writedata(wdata), .byteenable(be), .readdata(rdata), .waitrequest(waitreq));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Whole run needs a few hundred cycles; this ceiling only catches a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    u_host.access(1'b1, {i, 2'b00}, d, q);
  endtask
  task automatic rd(input logic [IDX_W-1:0] i, output logic [DATA_W-1:0] q);
    u_host.access(1'b0, {i, 2'b00}, '0, q);
  endtask
  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] q;
    rd(i, q);
    chk(n, e, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // Completion is polled a bounded number of times; the fixed walk is the longest
  task automatic switch_mode(input logic [15:0] code, input logic [DATA_W-1:0] ctrl);
    logic [DATA_W-1:0] q;
    int n;
    n = 0;
    q = '0;
    wr(IDX_MODE_REQ, {16'h0000, code});
    wr(IDX_CTRL, ctrl | 32'h0000_0001);
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 400) begin
      rd(IDX_STATUS, q);
      n++;
    end
    if (n == 400) mismatches++;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    stop = 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    chk_reg("req_word", IDX_MODE_REQ, 32'h0000_0000);
    chk_reg("status_reset", IDX_STATUS, {MODE_PARAM, 16'h0000});
    chk_reg("unmapped", 12'hA00, 32'h0000_0000);
    wr(IDX_CTRL, 32'h0000_0002);
    settle(3);
    chk("exch_refused", 32'h0, {31'h0, exch});
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_IRQ_EN, 32'h0000_0007);
    wr(IDX_SLV_CNT, 32'h0000_0002);
    wr(IDX_LEN_BASE, 32'h0000_0A05);
    wr(IDX_LEN_BASE + 12'h001, 32'h0000_0203);
    switch_mode(MODE_EXT, 32'h0000_0000);
    chk_reg("result_ok", IDX_MODE_RES, {16'h0000, RESULT_OK});
    chk_reg("status_ext", IDX_STATUS, {MODE_EXT, 16'h0001});
    chk_reg("offset_1", IDX_OFF_BASE + 12'h001, 32'h000A_0005);
    chk_reg("irq_stat_ok", IDX_IRQ_STAT, 32'h0000_0001);
    chk("irq_level", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_CLR, 32'h0000_0007);
    settle(2);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(IDX_CTRL, 32'h0000_0000);
    settle(2);
    chk_reg("done_dropped", IDX_STATUS, {MODE_EXT, 16'h0000});
    wr(IDX_MODE_RES, 32'h0000_1234);
    chk_reg("result_ro", IDX_MODE_RES, 32'h0000_0000);
    switch_mode(16'h0005, 32'h0000_0000);
    chk_reg("result_fail", IDX_MODE_RES, {16'h0000, RESULT_FAIL});
    chk_reg("irq_stat_fail", IDX_IRQ_STAT, 32'h0000_0002);
    chk_reg("mode_kept", IDX_STATUS, {MODE_EXT, 16'h0001});
    wr(IDX_CTRL, 32'h0000_0000);
    settle(2);
    chk_reg("result_held", IDX_MODE_RES, {16'h0000, RESULT_FAIL});
    switch_mode(MODE_NORMAL, 32'h0000_0000);
    chk_reg("result_fixed", IDX_MODE_RES, {16'h0000, RESULT_OK});
    // Last of the sixty slots sits at 59 slots of 32 bytes
    chk_reg("offset_59", IDX_OFF_BASE + 12'h03B, 32'h0760_0760);
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_LEN_BASE, 32'h0000_00F5);
    switch_mode(MODE_EXT, 32'h0000_0000);
    chk_reg("len_over", IDX_MODE_RES, {16'h0000, RESULT_FAIL});
    chk_reg("mode_fixed", IDX_STATUS, {MODE_NORMAL, 16'h0001});
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_IRQ_CLR, 32'h0000_0007);
    wr(IDX_CTRL, 32'h0000_0002);
    settle(2);
    chk("exch_on", 32'h1, {31'h0, exch});
    @(posedge clock) stop <= 1'b1;
    settle(3);
    chk("exch_blank_sw", 32'h1, {31'h0, exch});
    chk("hold_blank_sw", 32'h1, {31'h0, hold});
    @(posedge clock) stop <= 1'b0;
    wr(IDX_CTRL, 32'h0001_0002);
    settle(2);
    chk("exch_sw_one", 32'h1, {31'h0, exch});
    @(posedge clock) stop <= 1'b1;
    settle(3);
    chk("exch_halted", 32'h0, {31'h0, exch});
    chk("hold_halted", 32'h0, {31'h0, hold});
    chk_reg("irq_stat_stop", IDX_IRQ_STAT, 32'h0000_0004);
    @(posedge clock) stop <= 1'b0;
    settle(3);
    chk("exch_resumed", 32'h1, {31'h0, exch});
    switch_mode(MODE_NORMAL, 32'h0001_0002);
    chk("exch_off_switch", 32'h0, {31'h0, exch});
    chk_reg("result_in_exch", IDX_MODE_RES, {16'h0000, RESULT_OK});
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_SLV_CNT, 32'h0000_0000);
    switch_mode(MODE_DIAG, 32'h0000_0000);
    chk_reg("mode_diag", IDX_STATUS, {MODE_DIAG, 16'h0001});
    wr(IDX_CTRL, 32'h0000_0000);
    switch_mode(MODE_EXT, 32'h0000_0000);
    chk_reg("cnt_zero", IDX_MODE_RES, {16'h0000, RESULT_FAIL});
    stop_test();
  end
endmodule
